// File: rtl/interrupt_source_vector_map.sv
// Interrupt and reset source arbiter with vector address generation.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`include "ivm_params.svh"

module interrupt_source_vector_map (
  // Clock and reset.
  input  wire logic                    CLK,
  input  wire logic                    RSTN,
  // Avalon-MM register slave.
  input  wire logic [4:0]              ADDRESS,
  input  wire logic                    READ,
  input  wire logic                    WRITE,
  input  wire logic [31:0]             WRITEDATA,
  output logic      [31:0]             READDATA,
  output logic                         WAITREQUEST,
  // Request sources.
  input  wire ivm_pkg::src_req_t       SRC_REQ,
  input  wire logic [5:0]              PIN_EDGE,
  input  wire logic                    VOLT_DETECT,
  input  wire ivm_pkg::reset_cause_t   RESET_CAUSE,
  input  wire logic                    RESET_PIN_N,
  input  wire logic                    DEBUG_EMULATION,
  // Core side.
  input  wire ivm_pkg::core_exec_t     CORE_EXEC,
  input  wire logic                    INT_ACK,
  output logic                         INT_REQUEST,
  output logic [15:0]                  INT_VECTOR,
  output logic                         RESTART
);
  import ivm_pkg::*;

  typedef struct packed {
    logic [`IVM_NSRC-1:0]   flag;
    logic [`IVM_NSRC-1:0]   block;
    logic [`IVM_NSRC-1:0]   prlow;
    logic [`IVM_NSRC-1:0]   prhigh;
    logic                   ie;
    logic [7:0]             vdlevel;
    logic [6:0]             cause;
    logic                   soft_pend;
    logic                   win_soft;
    logic [`IVM_RANK_W-1:0] win_idx;
    logic                   int_req;
    logic [15:0]            int_vec;
    logic [15:0]            last_vec;
    logic                   restart;
    logic                   waitreq;
    logic [31:0]            rdata;
    logic [5:0]             pin_s1;
    logic [5:0]             pin_s2;
    logic [5:0]             pin_d;
    logic                   dbg_s1;
    logic                   dbg_s2;
    logic                   rpin_s1;
    logic                   rpin_s2;
    logic                   rpin_d;
  } state_t;

  state_t st;
  state_t next_st;

  logic [`IVM_NSRC-1:0]   src_set;
  logic [`IVM_NSRC-1:0]   pend;
  logic                   found;
  logic [`IVM_RANK_W-1:0] best_idx;
  logic [1:0]             best_lvl;
  logic [1:0]             lvl;
  logic [6:0]             cause_set;
  logic                   bus_req;
  logic                   bus_go;
  logic [31:0]            rd_word;
  logic [`IVM_NSRC-1:0]   wmask;

  // Source slots in rank order; shared ranks OR their strobes.
  always_comb begin
    src_set     = '0;
    src_set[0]  = SRC_REQ.watchdog_interval_request;
    src_set[1]  = SRC_REQ.voltage_detect_request |
                  (VOLT_DETECT &
                   ~st.vdlevel[`IVM_VD_MODE_BIT]);
    src_set[2]  = st.pin_s2[0] & ~st.pin_d[0];
    src_set[3]  = st.pin_s2[1] & ~st.pin_d[1];
    src_set[4]  = st.pin_s2[2] & ~st.pin_d[2];
    src_set[5]  = st.pin_s2[3] & ~st.pin_d[3];
    src_set[6]  = st.pin_s2[4] & ~st.pin_d[4];
    src_set[7]  = st.pin_s2[5] & ~st.pin_d[5];
    src_set[8]  = SRC_REQ.serial2_tx_request |
                  SRC_REQ.serial2_sync_request |
                  SRC_REQ.serial2_simple_bus_request;
    src_set[9]  = SRC_REQ.serial2_rx_request;
    src_set[10] = SRC_REQ.serial2_rx_error_request;
    src_set[11] = SRC_REQ.dma_chan0_end_request;
    src_set[12] = SRC_REQ.dma_chan1_end_request;
    src_set[13] = SRC_REQ.serial0_tx_request |
                  SRC_REQ.serial0_sync_request |
                  SRC_REQ.serial0_simple_bus_request;
    src_set[14] = SRC_REQ.serial0_rx_request;
    src_set[15] = SRC_REQ.serial0_rx_error_request |
                  SRC_REQ.timer_ch1_upper_end_request;
    src_set[16] = SRC_REQ.serial1_tx_request;
    src_set[17] = SRC_REQ.serial1_rx_request |
                  SRC_REQ.serial1_sync_request |
                  SRC_REQ.serial1_simple_bus_request;
    src_set[18] = SRC_REQ.serial1_rx_error_request |
                  SRC_REQ.timer_ch3_upper_end_request;
    src_set[19] = SRC_REQ.second_bus_unit_end_request;
  end

  // Reset causes; the power-on cause is the reset value itself.
  always_comb begin
    cause_set = '0;
    cause_set[`IVM_CAUSE_PIN]    = st.rpin_d & ~st.rpin_s2;
    cause_set[`IVM_CAUSE_VOLT]   = VOLT_DETECT &
                                   st.vdlevel[`IVM_VD_MODE_BIT];
    cause_set[`IVM_CAUSE_WDOG]   = RESET_CAUSE.watchdog_overflow_cause;
    cause_set[`IVM_CAUSE_ILLEG]  = CORE_EXEC.exec &
                                   (CORE_EXEC.opcode ==
                                    `IVM_BAD_OPCODE) &
                                   ~st.dbg_s2;
    cause_set[`IVM_CAUSE_ACCESS] = RESET_CAUSE.bad_access_reset_cause;
    cause_set[`IVM_CAUSE_PARITY] = RESET_CAUSE.ram_parity_reset_cause;
  end

  // Bus handshake: one wait cycle, then the access completes.
  assign bus_req = READ | WRITE;
  assign bus_go  = bus_req & ~st.waitreq;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    rd_word = '0;
    unique case (ADDRESS)
      `IVM_OFS_FLAG:    rd_word[`IVM_NSRC-1:0] = st.flag;
      `IVM_OFS_BLOCK:   rd_word[`IVM_NSRC-1:0] = st.block;
      `IVM_OFS_PRLOW:   rd_word[`IVM_NSRC-1:0] = st.prlow;
      `IVM_OFS_PRHIGH:  rd_word[`IVM_NSRC-1:0] = st.prhigh;
      `IVM_OFS_CTRL:    rd_word[1:0] = {st.soft_pend, st.ie};
      `IVM_OFS_VDLEVEL: rd_word[7:0] = st.vdlevel;
      `IVM_OFS_CAUSE:   rd_word[6:0] = st.cause;
      `IVM_OFS_VECTOR:  rd_word[15:0] = st.last_vec;
      default:          rd_word = '0;
    endcase
  end

  assign wmask = WRITEDATA[`IVM_NSRC-1:0];

  // Next state: bus writes, flag set and clear, arbitration, restart.
  always_comb begin
    next_st = st;

    // Synchronisers for the pins; first stages feed only second stages.
    next_st.pin_s1  = PIN_EDGE;
    next_st.pin_s2  = st.pin_s1;
    next_st.pin_d   = st.pin_s2;
    next_st.dbg_s1  = DEBUG_EMULATION;
    next_st.dbg_s2  = st.dbg_s1;
    next_st.rpin_s1 = RESET_PIN_N;
    next_st.rpin_s2 = st.rpin_s1;
    next_st.rpin_d  = st.rpin_s2;

    next_st.waitreq = ~(bus_req & st.waitreq);
    if (bus_req & st.waitreq) begin
      next_st.rdata = rd_word;
    end

    // Software writes; flag and cause clear on writing one.
    if (bus_go & WRITE) begin
      unique case (ADDRESS)
        `IVM_OFS_FLAG:    next_st.flag   = st.flag & ~wmask;
        `IVM_OFS_BLOCK:   next_st.block  = wmask;
        `IVM_OFS_PRLOW:   next_st.prlow  = wmask;
        `IVM_OFS_PRHIGH:  next_st.prhigh = wmask;
        `IVM_OFS_CTRL:    next_st.ie     = WRITEDATA[0];
        `IVM_OFS_VDLEVEL: next_st.vdlevel = WRITEDATA[7:0];
        `IVM_OFS_CAUSE:   next_st.cause  = st.cause & ~WRITEDATA[6:0];
        default:          next_st.ie     = st.ie;
      endcase
    end

    // The core takes the offered vector and clears its source.
    if (INT_ACK & st.int_req) begin
      next_st.last_vec = st.int_vec;
      next_st.ie       = 1'b0;
      if (st.win_soft) begin
        next_st.soft_pend = 1'b0;
      end else begin
        next_st.flag[st.win_idx] = 1'b0;
      end
    end

    // Hardware sets win over any clear in the same cycle; only a reset cause clears a soft break set.
    next_st.flag  = next_st.flag | src_set;
    next_st.cause = next_st.cause | cause_set;
    if (CORE_EXEC.exec & CORE_EXEC.soft_break_instruction) begin
      next_st.soft_pend = 1'b1;
    end

    // Any reset cause restarts the core through the single vector.
    next_st.restart = |cause_set;
    if (|cause_set) begin
      next_st.soft_pend = 1'b0;
      next_st.ie        = 1'b0;
    end

    // Arbitration on the state about to be stored.
    pend     = next_st.flag & ~next_st.block;
    found    = 1'b0;
    best_idx = '0;
    best_lvl = 2'h3;
    lvl      = 2'h3;
    for (int i = 0; i < `IVM_NSRC; i++) begin
      lvl = {next_st.prhigh[i], next_st.prlow[i]};
      // Strict compare keeps the lower rank on equal level.
      if (pend[i] && (!found || lvl < best_lvl)) begin
        found    = 1'b1;
        best_lvl = lvl;
        best_idx = i[`IVM_RANK_W-1:0];
      end
    end

    // Soft break is non-maskable and ignores the enable.
    next_st.win_soft = next_st.soft_pend;
    next_st.win_idx  = best_idx;
    if (next_st.restart) begin
      next_st.int_req = 1'b0;
      next_st.int_vec = `IVM_VEC_RESET;
    end else if (next_st.soft_pend) begin
      next_st.int_req = 1'b1;
      next_st.int_vec = `IVM_VEC_BREAK;
    end else begin
      next_st.int_req = found & next_st.ie;
      next_st.int_vec = `IVM_VEC_BASE +
                        {10'h000, best_idx, 1'b0};
    end
  end

  // State register; the restart vector and power-on cause are reset values.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st          <= '0;
      st.block    <= `IVM_RST_BLOCK;
      st.prlow    <= `IVM_RST_PRIO;
      st.prhigh   <= `IVM_RST_PRIO;
      st.vdlevel  <= `IVM_RST_VDLEVEL;
      st.cause    <= `IVM_RST_CAUSE;
      st.int_vec  <= `IVM_VEC_RESET;
      st.waitreq  <= 1'b1;
      st.pin_s1   <= '0;
      st.rpin_s1  <= 1'b1;
      st.rpin_s2  <= 1'b1;
      st.rpin_d   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state register.
  assign READDATA    = st.rdata;
  assign WAITREQUEST = st.waitreq;
  assign INT_REQUEST = st.int_req;
  assign INT_VECTOR  = st.int_vec;
  assign RESTART     = st.restart;

endmodule // interrupt_source_vector_map

// File: shared/ivm_params.svh
// Constants of the interrupt source vector map: offsets, fields, resets.
// Notes on behaviour
// - Soft break raises non-maskable request, vector 007EH.
// - Every reset cause restarts through vector 0000H.
// - Executing opcode FFH causes illegal-instruction reset.
// - No illegal-instruction reset while under debug emulation.
// - Voltage detect resets only when mode bit 7 selects.
// - Simultaneous maskable requests served by priority level, then by rank, 0 highest.
// - Watchdog interval request takes rank 0, vector 0004H.
// - Voltage detect request takes rank 1, vector 0006H.
// - Six pin edge requests, ranks 2-7, 0008H-0012H.
// - Serial2 transmit/sync/bus share rank 8, vector 0014H.
// - Serial2 receive end takes rank 9, vector 0016H.
// - Serial2 receive error takes rank 10, vector 0018H.
// - Serial0 transmit/sync/bus share rank 13, vector 001EH.
// - Serial0 receive end takes rank 14, vector 0020H.
// - Serial0 error and timer1 upper share rank 15.
// - Serial1 transmit end takes rank 16, vector 0024H.
// - Serial1 receive/sync/bus share rank 17, vector 0026H.
// - Serial1 receive error takes rank 18, vector 0028H.
// - Timer3 upper end shares rank 18, vector 0028H.
// - Each source has request, block and two priority flags.
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH

`define IVM_NSRC        20
`define IVM_RANK_W      5
`define IVM_VEC_BASE    16'h0004
`define IVM_VEC_BREAK   16'h007E
`define IVM_VEC_RESET   16'h0000
`define IVM_BAD_OPCODE  8'hFF
`define IVM_VD_MODE_BIT 7

`define IVM_OFS_FLAG    5'h00
`define IVM_OFS_BLOCK   5'h04
`define IVM_OFS_PRLOW   5'h08
`define IVM_OFS_PRHIGH  5'h0C
`define IVM_OFS_CTRL    5'h10
`define IVM_OFS_VDLEVEL 5'h14
`define IVM_OFS_CAUSE   5'h18
`define IVM_OFS_VECTOR  5'h1C

`define IVM_RST_BLOCK   20'hFFFFF
`define IVM_RST_PRIO    20'hFFFFF
`define IVM_RST_VDLEVEL 8'h00
`define IVM_RST_CAUSE   7'h02

`define IVM_CAUSE_PIN    0
`define IVM_CAUSE_POWER  1
`define IVM_CAUSE_VOLT   2
`define IVM_CAUSE_WDOG   3
`define IVM_CAUSE_ILLEG  4
`define IVM_CAUSE_ACCESS 5
`define IVM_CAUSE_PARITY 6

`endif

// File: shared/ivm_pkg.sv
// Types of the interrupt source vector map.
package ivm_pkg;

  // Maskable request strobes from on-chip units, one cycle each.
  typedef struct packed {
    logic watchdog_interval_request;
    logic voltage_detect_request;
    logic serial2_tx_request;
    logic serial2_sync_request;
    logic serial2_simple_bus_request;
    logic serial2_rx_request;
    logic serial2_rx_error_request;
    logic dma_chan0_end_request;
    logic dma_chan1_end_request;
    logic serial0_tx_request;
    logic serial0_sync_request;
    logic serial0_simple_bus_request;
    logic serial0_rx_request;
    logic serial0_rx_error_request;
    logic timer_ch1_upper_end_request;
    logic serial1_tx_request;
    logic serial1_rx_request;
    logic serial1_sync_request;
    logic serial1_simple_bus_request;
    logic serial1_rx_error_request;
    logic timer_ch3_upper_end_request;
    logic second_bus_unit_end_request;
  } src_req_t;

  // Reset cause strobes from on-chip monitors, one cycle each.
  typedef struct packed {
    logic watchdog_overflow_cause;
    logic bad_access_reset_cause;
    logic ram_parity_reset_cause;
  } reset_cause_t;

  // Instruction execution report from the core.
  typedef struct packed {
    logic       exec;
    logic [7:0] opcode;
    logic       soft_break_instruction;
  } core_exec_t;

endpackage

// File: tb/ivm_assertions.sv
// Checker of vector, restart and bus answer timing at the arbiter ports.
module ivm_assertions (
  // Clock and reset.
  input wire logic                  CLK,
  input wire logic                  RSTN,
  // Bus handshake.
  input wire logic                  READ,
  input wire logic                  WRITE,
  input wire logic                  WAITREQUEST,
  // Sources and core side.
  input wire ivm_pkg::reset_cause_t RESET_CAUSE,
  input wire logic                  DEBUG_EMULATION,
  input wire ivm_pkg::core_exec_t   CORE_EXEC,
  input wire logic                  INT_ACK,
  input wire logic                  INT_REQUEST,
  input wire logic [15:0]           INT_VECTOR,
  input wire logic                  RESTART
);
  timeunit 1ns;
  timeprecision 1ns;
  import ivm_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Debug level goes through a synchroniser, so it must be settled first.
  break_vec_a: assert property (
    CORE_EXEC.exec && CORE_EXEC.soft_break_instruction
    |=> INT_REQUEST && INT_VECTOR == 16'h007E)
    else $error("Soft break vector wrong.");
  restart_vec_a: assert property (RESTART |-> INT_VECTOR == 16'h0000)
    else $error("Restart vector wrong.");
  wdog_rst_a: assert property (
    RESET_CAUSE.watchdog_overflow_cause |=> RESTART)
    else $error("Watchdog cause gave no restart.");
  parity_rst_a: assert property (
    RESET_CAUSE.ram_parity_reset_cause |=> RESTART ##1 !RESTART)
    else $error("Parity restart pulse wrong.");
  trap_rst_a: assert property (
    (!DEBUG_EMULATION [*4]) ##0 (CORE_EXEC.exec && CORE_EXEC.opcode == 8'hFF)
    |=> RESTART)
    else $error("Illegal opcode gave no restart.");
  debug_quiet_a: assert property (
    (DEBUG_EMULATION [*4]) ##0 (CORE_EXEC.exec && CORE_EXEC.opcode == 8'hFF)
    |=> !RESTART)
    else $error("Restart under debug emulation.");
  ack_drop_a: assert property (INT_ACK && INT_REQUEST |=> !INT_REQUEST)
    else $error("Request stayed after acknowledge.");
  vec_map_a: assert property (INT_REQUEST |-> INT_VECTOR == 16'h007E ||
    (INT_VECTOR inside {[16'h0004:16'h002A]} && !INT_VECTOR[0]))
    else $error("Offered vector outside table.");
  bus_answer_a: assert property (
    (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST)
    else $error("Bus answer timing wrong.");
endmodule // ivm_assertions

// File: tb/core_model.sv
// Behavioural core that acknowledges offered vectors and loads them.
module core_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rstn,
  // Arbiter side.
  input  wire logic        int_request,
  input  wire logic [15:0] int_vector,
  output logic             int_ack,
  // Bench side.
  input  wire logic [3:0]  delay,
  output logic [15:0]      pc,
  output int               taken
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  // A slow core waits delay cycles; the ack stands one cycle only.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      int_ack <= 1'b0;
      pc <= 16'h0000;
      taken <= 0;
      wait_cnt <= 0;
    end else if (int_ack || !int_request) begin
      int_ack <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt >= delay) begin
      int_ack <= 1'b1;
      pc <= int_vector;
      taken <= taken + 1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule // core_model

// File: tb/testbench.sv
// Self-checking bench of the interrupt source vector map.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ivm_pkg::*;
  logic         CLK, RSTN, READ, WRITE, WAITREQUEST, VOLT_DETECT;
  logic         RESET_PIN_N, DEBUG_EMULATION, INT_ACK, INT_REQUEST, RESTART;
  logic [4:0]   ADDRESS;
  logic [31:0]  WRITEDATA, READDATA;
  logic [5:0]   PIN_EDGE;
  logic [15:0]  INT_VECTOR, pc;
  logic [3:0]   delay;
  src_req_t     SRC_REQ;
  reset_cause_t RESET_CAUSE;
  core_exec_t   CORE_EXEC;
  int           errors, cmp_count, taken, restarts;
  // Rank of each request bit, bit 0 first.
  int rk[22] = '{19,18,18,17,17,17,16,15,15,14,13,13,13,12,11,10,9,8,8,8,1,0};

  interrupt_source_vector_map interrupt_source_vector_map_i (.*);
  core_model core_model_i (.clk(CLK), .rstn(RSTN), .int_request(INT_REQUEST),
    .int_vector(INT_VECTOR), .int_ack(INT_ACK), .delay(delay), .pc(pc),
    .taken(taken));

  // Clock of 100 ns; restarts are counted on the falling edge to avoid races.
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  always @(negedge CLK) if (RESTART === 1'b1) restarts <= restarts + 1;

  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus access; waitrequest and read data are taken at the same edge.
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge CLK);
    ADDRESS <= a;
    WRITEDATA <= d;
    READ <= !wr;
    WRITE <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge CLK);
      if (WAITREQUEST === 1'b0) break;
    end
    if (n == 20) begin
      check("waitrequest", 0, 1);
      tally_and_finish();
    end
    q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask

  task automatic wr(logic [4:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(logic [4:0] a, logic [31:0] exp, string name);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(name, exp, q);
  endtask

  // Waits for the core count (sel 0) or the restart count (sel 1) to move.
  task automatic wait_for(int sel, int c0);
    int n;
    for (n = 0; n < 40 && (sel ? restarts : taken) == c0; n++) @(posedge CLK);
    if (n == 40) begin
      check("handshake", 1, 0);
      tally_and_finish();
    end
  endtask

  task automatic expect_vec(logic [15:0] v);
    wait_for(0, taken);
    check("vector", v, pc);
  endtask

  task automatic t_map();
    for (int i = 0; i < 22; i++) begin
      wr(5'h10, 32'h1);
      @(posedge CLK) SRC_REQ <= src_req_t'(22'h1 << i);
      @(posedge CLK) SRC_REQ <= '0;
      expect_vec(16'h0004 + 16'(2 * rk[i]));
    end
    for (int i = 0; i < 6; i++) begin
      wr(5'h10, 32'h1);
      @(posedge CLK) PIN_EDGE <= 6'h1 << i;
      expect_vec(16'h0008 + 16'(2 * i));
      PIN_EDGE <= 6'h00;
    end
  endtask

  // Three requests pend while disabled, then leave in rank order.
  task automatic t_prio();
    logic [15:0] exp[3] = '{16'h0008, 16'h0016, 16'h0026};
    delay = 4'h3;
    @(posedge CLK) SRC_REQ <= src_req_t'(22'h10020);
    PIN_EDGE <= 6'h01;
    @(posedge CLK) SRC_REQ <= '0;
    for (int k = 0; k < 3; k++) begin
      wr(5'h10, 32'h1);
      expect_vec(exp[k]);
    end
    PIN_EDGE <= 6'h00;
    delay = 4'h0;
  endtask

  task automatic t_block_break();
    wr(5'h04, 32'h1);
    @(posedge CLK) SRC_REQ <= src_req_t'(22'h200000);
    @(posedge CLK) SRC_REQ <= '0;
    wr(5'h10, 32'h1);
    repeat (8) @(posedge CLK);
    check("request", 0, INT_REQUEST);
    wr(5'h04, 32'h0);
    expect_vec(16'h0004);
    @(posedge CLK) CORE_EXEC <= 10'h201;
    @(posedge CLK) CORE_EXEC <= '0;
    expect_vec(16'h007E);
    wr(5'h10, 32'h1);
    @(posedge CLK) VOLT_DETECT <= 1'b1;
    @(posedge CLK) VOLT_DETECT <= 1'b0;
    expect_vec(16'h0006);
  endtask

  // One reset cause; the pin is held low a few cycles for its synchroniser.
  task automatic cause(int k);
    int r0;
    r0 = restarts;
    @(posedge CLK);
    case (k)
      0: RESET_PIN_N <= 1'b0;
      2: VOLT_DETECT <= 1'b1;
      3: RESET_CAUSE <= 3'b100;
      4: CORE_EXEC <= 10'h3FE;
      5: RESET_CAUSE <= 3'b010;
      default: RESET_CAUSE <= 3'b001;
    endcase
    if (k == 0) repeat (3) @(posedge CLK);
    else @(posedge CLK);
    {VOLT_DETECT, RESET_CAUSE, CORE_EXEC} <= '0;
    RESET_PIN_N <= 1'b1;
    wait_for(1, r0);
    rd_chk(5'h18, 32'h1 << k, "cause");
    wr(5'h18, 32'h1 << k);
  endtask

  initial begin
    {RSTN, READ, WRITE, VOLT_DETECT, DEBUG_EMULATION, ADDRESS} = '0;
    {WRITEDATA, PIN_EDGE, SRC_REQ, RESET_CAUSE, CORE_EXEC, delay} = '0;
    {errors, cmp_count, restarts} = '0;
    RESET_PIN_N = 1'b1;
    repeat (6) @(posedge CLK);
    RSTN <= 1'b1;
    rd_chk(5'h04, 32'h000FFFFF, "block");
    rd_chk(5'h18, 32'h00000002, "cause");
    rd_chk(5'h02, 32'h00000000, "unmapped");
    wr(5'h04, 32'h0);
    wr(5'h18, 32'h2);
    t_map();
    t_prio();
    t_block_break();
    wr(5'h14, 32'h80);
    foreach (rk[k]) if (k < 7 && k != 1) cause(k);
    DEBUG_EMULATION <= 1'b1;
    repeat (4) @(posedge CLK);
    cmp_count = cmp_count;
    @(posedge CLK) CORE_EXEC <= 10'h3FE;
    @(posedge CLK) CORE_EXEC <= '0;
    repeat (6) @(posedge CLK);
    rd_chk(5'h18, 32'h0, "cause");
    tally_and_finish();
  end
endmodule // testbench

bind interrupt_source_vector_map ivm_assertions ivm_assertions_i (.CLK, .RSTN,
  .READ, .WRITE, .WAITREQUEST, .RESET_CAUSE, .DEBUG_EMULATION, .CORE_EXEC,
  .INT_ACK, .INT_REQUEST, .INT_VECTOR, .RESTART);
